// ==== cpu_decode_pkg.sv ====
// Shared codes, opcode fields and reset values for the instruction class decoder
// Operation
// [RULE1] Relative addressing used only by branches
// [RULE2] Taken branch adds signed offset to PC
// [RULE3] Untaken branch continues with next instruction
// [RULE4] Offset is 8-bit two's complement, -128..+127
// [RULE5] Register/memory: accumulator or index plus memory
// [RULE6] Read-modify-write reads, alters, stores same place
// [RULE7] Software avoids read-modify-write on write-only registers
// [RULE8] Bit set/clear decoded with direct addressing only
// [RULE9] Test negative/zero skips the write-back
// [RULE10] Jumps take no register operand, always redirect
// [RULE11] Bit-test branch: opcode, direct address, offset
// [RULE12] Bit number and polarity come from opcode
// [RULE13] Bit-test branch taken only on matching polarity
// [RULE14] Bit-test branch copies tested bit to carry
// [RULE15] Set/clear any bit in first 256 bytes
// [RULE16] Test any bit in first 256 bytes
// [RULE17] Every opcode falls in exactly one group
// [RULE18] Both shift-left names behave identically
// [RULE19] Oscillator halt stops clock, enables interrupt wake
// [RULE20] Wait halts CPU clock and clears mask
// [RULE21] Branches test interrupt pin and mask flag
// [RULE22] Multiply: high byte to index, low to accumulator
// [RULE23] Never-branch discards offset, falls through
`default_nettype none
package cpu_decode_pkg;
  typedef enum logic [2:0] {CLS_REG_MEM, CLS_RMW, CLS_JUMP_BRANCH, CLS_BIT_MANIP,
                            CLS_CONTROL} class_type;
  typedef enum logic [2:0] {MODE_INH, MODE_IMM, MODE_DIR, MODE_EXT, MODE_IX, MODE_IX1,
                            MODE_IX2, MODE_REL} mode_type;
  typedef enum logic [1:0] {LOC_NONE, LOC_MEM, LOC_ACC, LOC_IDX} loc_type;
  // Opcode rows (upper nibble)
  localparam logic [3:0] ROW_BIT_TEST  = 4'h0;
  localparam logic [3:0] ROW_BIT_MANIP = 4'h1;
  localparam logic [3:0] ROW_REL       = 4'h2;
  localparam logic [3:0] ROW_RMW_DIR   = 4'h3;
  localparam logic [3:0] ROW_RMW_ACC   = 4'h4;
  localparam logic [3:0] ROW_RMW_IDX   = 4'h5;
  localparam logic [3:0] ROW_RMW_IX1   = 4'h6;
  localparam logic [3:0] ROW_RMW_IX    = 4'h7;
  localparam logic [3:0] ROW_IMM       = 4'hA;
  localparam logic [3:0] ROW_DIR       = 4'hB;
  localparam logic [3:0] ROW_EXT       = 4'hC;
  localparam logic [3:0] ROW_IX2       = 4'hD;
  localparam logic [3:0] ROW_IX1       = 4'hE;
  // Read-modify-write operations (lower nibble)
  localparam logic [3:0] RMW_NEG = 4'h0;
  localparam logic [3:0] RMW_COM = 4'h3;
  localparam logic [3:0] RMW_LSR = 4'h4;
  localparam logic [3:0] RMW_ROR = 4'h6;
  localparam logic [3:0] RMW_ASR = 4'h7;
  localparam logic [3:0] RMW_SHL = 4'h8;
  localparam logic [3:0] RMW_ROL = 4'h9;
  localparam logic [3:0] RMW_DEC = 4'hA;
  localparam logic [3:0] RMW_INC = 4'hC;
  localparam logic [3:0] RMW_TST = 4'hD;
  localparam logic [3:0] RMW_CLR = 4'hF;
  // Register/memory operations (lower nibble)
  localparam logic [3:0] RM_CPX = 4'h3;
  localparam logic [3:0] RM_STA = 4'h7;
  localparam logic [3:0] RM_JMP = 4'hC;
  localparam logic [3:0] RM_JSR = 4'hD;
  localparam logic [3:0] RM_LDX = 4'hE;
  localparam logic [3:0] RM_STX = 4'hF;
  // Relative branch conditions (lower nibble)
  localparam logic [3:0] BR_ALWAYS   = 4'h0;
  localparam logic [3:0] BR_NEVER    = 4'h1;
  localparam logic [3:0] BR_HI       = 4'h2;
  localparam logic [3:0] BR_LS       = 4'h3;
  localparam logic [3:0] BR_CC       = 4'h4;
  localparam logic [3:0] BR_CS       = 4'h5;
  localparam logic [3:0] BR_NE       = 4'h6;
  localparam logic [3:0] BR_EQ       = 4'h7;
  localparam logic [3:0] BR_HCC      = 4'h8;
  localparam logic [3:0] BR_HCS      = 4'h9;
  localparam logic [3:0] BR_PL       = 4'hA;
  localparam logic [3:0] BR_MI       = 4'hB;
  localparam logic [3:0] BR_MASK_CLR = 4'hC;
  localparam logic [3:0] BR_MASK_SET = 4'hD;
  localparam logic [3:0] BR_IRQ_LOW  = 4'hE;
  localparam logic [3:0] BR_IRQ_HIGH = 4'hF;
  // Whole opcodes
  localparam logic [7:0] OP_MUL  = 8'h42;
  localparam logic [7:0] OP_STOP = 8'h8E;
  localparam logic [7:0] OP_WAIT = 8'h8F;
  localparam logic [7:0] OP_BSR  = 8'hAD;
  // Direct page high byte, instruction lengths, reset values
  localparam logic [7:0]  DIRECT_PAGE = 8'h00;
  localparam logic [1:0]  LEN_ONE     = 2'd1;
  localparam logic [1:0]  LEN_TWO     = 2'd2;
  localparam logic [1:0]  LEN_THREE   = 2'd3;
  localparam logic [15:0] RST_ADDR    = 16'h0000;
  localparam logic [7:0]  RST_BYTE    = 8'h00;
endpackage
`default_nettype wire

// ==== cpu_instruction_class_decode.sv ====
// Opcode group decode, operand routing, RMW/bit results and next program counter
`default_nettype none
module cpu_instruction_class_decode
  import cpu_decode_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // Instruction request
  input  wire logic        start,
  input  wire logic [7:0]  opcode,
  input  wire logic [7:0]  byte1,
  input  wire logic [7:0]  byte2,
  input  wire logic [15:0] pc_now,
  // CPU state and memory read data
  input  wire logic [7:0]  acc,
  input  wire logic [7:0]  idx,
  input  wire logic        flag_h,
  input  wire logic        flag_i,
  input  wire logic        flag_n,
  input  wire logic        flag_z,
  input  wire logic        flag_c,
  input  wire logic [7:0]  mem_data,
  // External interrupt pin
  input  wire logic        irq_pin_n,
  // Decode result
  output logic             done,
  output var class_type    instr_class,
  output var mode_type     addr_mode,
  output var loc_type      operand_loc,
  output logic [15:0]      eff_addr,
  output logic             mem_read,
  output logic             mem_write,
  // Flow
  output logic [15:0]      next_pc,
  output logic             branch_taken,
  // Data results
  output logic [7:0]       result_data,
  output logic             result_n,
  output logic             result_z,
  output logic             carry_update,
  output logic             carry_value,
  output logic             mul_load,
  output logic [7:0]       mul_hi,
  output logic [7:0]       mul_lo,
  // CPU control
  output logic             stop_req,
  output logic             wait_req,
  output logic             irq_wake_en,
  output logic             mask_clear
);
  typedef enum logic {ST_IDLE, ST_REPORT} state_type;

  function automatic logic rmw_legal(input logic [3:0] lo);
    rmw_legal = (lo == RMW_NEG) || (lo == RMW_COM) || (lo == RMW_LSR) ||
                (lo == RMW_ROR) || (lo == RMW_ASR) || (lo == RMW_SHL) ||
                (lo == RMW_ROL) || (lo == RMW_DEC) || (lo == RMW_INC) ||
                (lo == RMW_TST) || (lo == RMW_CLR);
  endfunction

  function automatic logic rmw_sets_carry(input logic [3:0] lo);
    rmw_sets_carry = (lo == RMW_NEG) || (lo == RMW_COM) || (lo == RMW_LSR) ||
                     (lo == RMW_ROR) || (lo == RMW_ASR) || (lo == RMW_SHL) ||
                     (lo == RMW_ROL);
  endfunction

  // Returns {carry, result}; one shift-left entry serves both shift-left names
  function automatic logic [8:0] rmw_alu(input logic [3:0] lo, input logic [7:0] v,
                                         input logic c);
    case (lo)
      RMW_NEG: rmw_alu = {(v != 8'h00), 8'(8'h00 - v)};
      RMW_COM: rmw_alu = {1'b1, ~v};
      RMW_LSR: rmw_alu = {v[0], 1'b0, v[7:1]};
      RMW_ROR: rmw_alu = {v[0], c, v[7:1]};
      RMW_ASR: rmw_alu = {v[0], v[7], v[7:1]};
      RMW_SHL: rmw_alu = {v[7], v[6:0], 1'b0};     // RULE18
      RMW_ROL: rmw_alu = {v[7], v[6:0], c};
      RMW_DEC: rmw_alu = {c, 8'(v - 8'h01)};
      RMW_INC: rmw_alu = {c, 8'(v + 8'h01)};
      RMW_CLR: rmw_alu = {c, 8'h00};
      default: rmw_alu = {c, v};
    endcase
  endfunction

  function automatic mode_type mode_of(input logic [7:0] op);
    case (op[7:4])
      ROW_BIT_TEST, ROW_BIT_MANIP, ROW_RMW_DIR, ROW_DIR: mode_of = MODE_DIR; // RULE8
      ROW_REL:                  mode_of = MODE_REL;  // RULE1
      ROW_RMW_IX1, ROW_IX1:     mode_of = MODE_IX1;
      ROW_RMW_IX, 4'hF:         mode_of = MODE_IX;
      ROW_IMM:                  mode_of = (op == OP_BSR) ? MODE_REL : MODE_IMM;
      ROW_EXT:                  mode_of = MODE_EXT;
      ROW_IX2:                  mode_of = MODE_IX2;
      default:                  mode_of = MODE_INH;
    endcase
  endfunction

  function automatic logic [1:0] len_of(input mode_type m, input logic bit_test);
    case (m)
      MODE_INH, MODE_IX:  len_of = LEN_ONE;
      MODE_EXT, MODE_IX2: len_of = LEN_THREE;
      default:            len_of = bit_test ? LEN_THREE : LEN_TWO; // RULE11
    endcase
  endfunction

  // Interrupt pin synchroniser
  logic irq_meta_reg;
  logic irq_sync_reg;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_meta_reg <= 1'b1;
      irq_sync_reg <= 1'b1;
    end
    else
    begin
      irq_meta_reg <= irq_pin_n;
      irq_sync_reg <= irq_meta_reg;
    end
  end

  // Opcode decode
  wire [3:0] op_hi       = opcode[7:4];
  wire [3:0] op_lo       = opcode[3:0];
  wire [2:0] bit_num     = opcode[3:1];                                  // RULE12
  wire       is_bit_test = (op_hi == ROW_BIT_TEST);
  wire       is_bit_man  = (op_hi == ROW_BIT_MANIP);
  wire       is_rel      = (op_hi == ROW_REL);
  wire       is_mul      = (opcode == OP_MUL);
  wire       is_bsr      = (opcode == OP_BSR);
  wire       rmw_row     = (op_hi >= ROW_RMW_DIR) && (op_hi <= ROW_RMW_IX);
  wire       is_rmw      = rmw_row && rmw_legal(op_lo) && !is_mul;
  wire       is_tst      = is_rmw && (op_lo == RMW_TST);
  wire       rm_row      = (op_hi >= ROW_IMM);
  wire       is_jmp      = rm_row && (op_hi != ROW_IMM) && (op_lo == RM_JMP);
  wire       is_jsr      = rm_row && (op_hi != ROW_IMM) && (op_lo == RM_JSR);
  wire       imm_bad     = (op_hi == ROW_IMM) &&
                           ((op_lo == RM_STA) || (op_lo == RM_STX) || (op_lo == RM_JMP));
  wire       is_store    = rm_row && ((op_lo == RM_STA) || (op_lo == RM_STX)) && !imm_bad;
  wire       is_rm       = (rm_row && !is_jmp && !is_jsr && !is_bsr && !imm_bad) || is_mul;
  wire       is_jump     = is_rel || is_jmp || is_jsr || is_bsr;
  wire       is_stop     = (opcode == OP_STOP);
  wire       is_wait     = (opcode == OP_WAIT);

  // One group per opcode; undefined codes fall into the control group
  wire class_type class_w = (is_bit_test || is_bit_man) ? CLS_BIT_MANIP   : // RULE17
                            is_jump                     ? CLS_JUMP_BRANCH :
                            is_rmw                      ? CLS_RMW         :
                            is_rm                       ? CLS_REG_MEM     : CLS_CONTROL;
  wire mode_type  mode_w  = mode_of(opcode);
  wire [15:0]     seq_pc  = pc_now + {14'h0000, len_of(mode_w, is_bit_test)};

  // Effective data or jump address; relative offsets never address data
  wire [8:0]  ix1_sum  = {1'b0, idx} + {1'b0, byte1};
  wire [15:0] ea_w     = (mode_w == MODE_DIR) ? {DIRECT_PAGE, byte1} :   // RULE15 RULE16
                         (mode_w == MODE_EXT) ? {byte1, byte2} :
                         (mode_w == MODE_IX)  ? {DIRECT_PAGE, idx} :
                         (mode_w == MODE_IX1) ? {7'h00, ix1_sum} :
                         (mode_w == MODE_IX2) ? 16'({byte1, byte2} + {8'h00, idx}) : RST_ADDR;
  wire        mem_mode = (mode_w != MODE_INH) && (mode_w != MODE_IMM) &&
                         (mode_w != MODE_REL);                           // RULE1
  wire        data_mem = mem_mode && !is_jmp && !is_jsr;                 // RULE10

  // Operand routing
  wire rm_idx = (op_lo == RM_CPX) || (op_lo == RM_LDX) || (op_lo == RM_STX);
  wire loc_type loc_w = (is_rmw && op_hi == ROW_RMW_ACC) ? LOC_ACC :     // RULE6
                        (is_rmw && op_hi == ROW_RMW_IDX) ? LOC_IDX :
                        (is_rmw || is_bit_man)           ? LOC_MEM :
                        (is_rm && !is_mul)               ? (rm_idx ? LOC_IDX : LOC_ACC) :
                        LOC_NONE;                                        // RULE5
  wire rd_w = (is_rm && data_mem && !is_store) ||                        // RULE5
              (is_rmw && data_mem) || is_bit_test || is_bit_man;         // RULE16
  wire wr_w = (is_rm && is_store) || (is_rmw && data_mem && !is_tst) ||  // RULE9
              is_bit_man;                                                // RULE15

  // Read-modify-write and bit results
  wire [7:0] rmw_src   = (loc_w == LOC_ACC) ? acc : (loc_w == LOC_IDX) ? idx : mem_data;
  wire [8:0] rmw_out   = rmw_alu(op_lo, rmw_src, flag_c);                // RULE6
  wire [7:0] bit_mask  = 8'(8'h01 << bit_num);
  wire [7:0] bit_res   = opcode[0] ? (mem_data & ~bit_mask) : (mem_data | bit_mask);
  wire       tested    = mem_data[bit_num];
  wire [15:0] product  = {8'h00, acc} * {8'h00, idx};                    // RULE22
  wire [7:0] result_w  = is_rmw ? rmw_out[7:0] : is_bit_man ? bit_res :
                         is_mul ? product[7:0] : RST_BYTE;
  wire       carry_upd = is_bit_test || (is_rmw && rmw_sets_carry(op_lo)) || is_mul;
  wire       carry_w   = is_bit_test ? tested : is_mul ? 1'b0 : rmw_out[8]; // RULE14

  // Branch resolution
  wire [7:0]  off_byte   = is_bit_test ? byte2 : byte1;                  // RULE11
  wire [15:0] offset_ext = {{8{off_byte[7]}}, off_byte};
  wire [3:0]  cond_sel   = is_bsr ? BR_ALWAYS : op_lo;
  wire        cond_true;
  wire [15:0] target;

  rel_branch_unit u_branch (
    .cond_sel     (cond_sel),
    .bit_test     (is_bit_test),
    .bit_polarity (~opcode[0]),
    .bit_value    (tested),
    .flag_h       (flag_h),
    .flag_i       (flag_i),
    .flag_n       (flag_n),
    .flag_z       (flag_z),
    .flag_c       (flag_c),
    .irq_level    (irq_sync_reg),
    .seq_pc       (seq_pc),
    .offset       (off_byte),
    .cond_true    (cond_true),
    .target       (target)
  );

  wire        rel_kind = is_rel || is_bit_test || is_bsr;
  wire        taken_w  = is_jmp || is_jsr || (rel_kind && cond_true);   // RULE10 RULE13
  wire [15:0] npc_w    = (is_jmp || is_jsr) ? ea_w :                     // RULE10
                         (rel_kind && cond_true) ? target : seq_pc;      // RULE2 RULE3

  // Report state
  state_type state_reg;
  state_type state_next;

  assign state_next = start ? ST_REPORT : ST_IDLE;
  assign done       = (state_reg == ST_REPORT);

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      state_reg <= ST_IDLE;
    else
      state_reg <= state_next;
  end

  // Decode and flow outputs
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      instr_class  <= CLS_CONTROL;
      addr_mode    <= MODE_INH;
      operand_loc  <= LOC_NONE;
      eff_addr     <= RST_ADDR;
      mem_read     <= 1'b0;
      mem_write    <= 1'b0;
      next_pc      <= RST_ADDR;
      branch_taken <= 1'b0;
    end
    else if (start)
    begin
      instr_class  <= class_w;
      addr_mode    <= mode_w;
      operand_loc  <= loc_w;
      eff_addr     <= data_mem || is_jmp || is_jsr ? ea_w : RST_ADDR;
      mem_read     <= rd_w;
      mem_write    <= wr_w;
      next_pc      <= npc_w;
      branch_taken <= taken_w;
    end
  end

  // Data and control outputs
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      result_data  <= RST_BYTE;
      result_n     <= 1'b0;
      result_z     <= 1'b0;
      carry_update <= 1'b0;
      carry_value  <= 1'b0;
      mul_load     <= 1'b0;
      mul_hi       <= RST_BYTE;
      mul_lo       <= RST_BYTE;
      stop_req     <= 1'b0;
      wait_req     <= 1'b0;
      irq_wake_en  <= 1'b0;
      mask_clear   <= 1'b0;
    end
    else if (start)
    begin
      result_data  <= result_w;
      result_n     <= result_w[7];
      result_z     <= (result_w == RST_BYTE);
      carry_update <= carry_upd;                 // RULE14
      carry_value  <= carry_w;
      mul_load     <= is_mul;
      mul_hi       <= product[15:8];             // RULE22
      mul_lo       <= product[7:0];
      stop_req     <= is_stop;                   // RULE19
      wait_req     <= is_wait;                   // RULE20
      irq_wake_en  <= is_stop;                   // RULE19
      mask_clear   <= is_stop || is_wait;        // RULE20
    end
    else
    begin
      carry_update <= 1'b0;
      mul_load     <= 1'b0;
      stop_req     <= 1'b0;
      wait_req     <= 1'b0;
      irq_wake_en  <= 1'b0;
      mask_clear   <= 1'b0;
    end
  end

  // Checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_start_op(logic [7:0] op);
    start && (opcode == op);
  endsequence

  sequence s_wait_effect;
    wait_req && mask_clear && !stop_req;
  endsequence

  AST_GROUP_REL: assert property (start && is_rel |=> done && // RULE17
    instr_class == CLS_JUMP_BRANCH && addr_mode == MODE_REL && !mem_read)
    else $error("relative opcode not decoded as branch");

  AST_TAKEN_TARGET: assert property (start && rel_kind && cond_true |=> // RULE2
    branch_taken && next_pc == 16'($past(seq_pc) + $past(offset_ext)))
    else $error("taken branch target wrong");

  AST_NOT_TAKEN: assert property (start && rel_kind && !cond_true |=> // RULE3
    !branch_taken && next_pc == $past(seq_pc))
    else $error("untaken branch did not fall through");

  AST_NEVER: assert property (s_start_op(8'h21) |=> // RULE23
    !branch_taken && next_pc == 16'($past(pc_now) + 16'h0002))
    else $error("never-branch changed flow");

  AST_BIT_CARRY: assert property (start && is_bit_test |=> // RULE14
    carry_update && carry_value == $past(tested) ##1
    (carry_update == $past(start && carry_upd)))
    else $error("bit-test carry not copied");

  AST_BIT_LEN: assert property (start && is_bit_test && !cond_true |=> // RULE11
    next_pc == 16'($past(pc_now) + 16'h0003) && eff_addr[15:8] == DIRECT_PAGE)
    else $error("bit-test branch length or address wrong");

  AST_TST_NO_WRITE: assert property (start && is_tst |=> !mem_write) // RULE9
    else $error("test operation wrote back");

  AST_BITMAN_DIRECT: assert property (start && is_bit_man |=> // RULE8
    addr_mode == MODE_DIR && mem_write && eff_addr == {DIRECT_PAGE, $past(byte1)})
    else $error("bit set or clear not direct");

  AST_MUL: assert property (s_start_op(OP_MUL) |=> // RULE22
    mul_load && {mul_hi, mul_lo} == {8'h00, $past(acc)} * {8'h00, $past(idx)})
    else $error("multiply product misplaced");

  AST_WAIT: assert property (s_start_op(OP_WAIT) |=> s_wait_effect ##1 // RULE20
    (wait_req == $past(start && is_wait)))
    else $error("wait control not issued");

  AST_JUMP: assert property (start && (is_jmp || is_jsr) |=> // RULE10
    branch_taken && next_pc == $past(ea_w) && operand_loc == LOC_NONE)
    else $error("jump did not redirect");
endmodule
`default_nettype wire

// ==== page_mem_model.sv ====
// Direct-page memory model that serves operand reads and takes write-backs
`default_nettype none
module page_mem_model
(
  // Clock
  input  wire logic        sys_clk,
  // Read port, addressed by the direct address byte
  input  wire logic [7:0]  rd_addr,
  output logic [7:0]       rd_data,
  // Write-back from the decoder
  input  wire logic        wr_en,
  input  wire logic [15:0] wr_addr,
  input  wire logic [7:0]  wr_data,
  // Preload from the bench
  input  wire logic        ld_en,
  input  wire logic [7:0]  ld_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem_reg [256];
  // Bench never aims a modify op at a write-only place
  assign rd_data = mem_reg[rd_addr];
  // Writes outside the first page are dropped
  always @(posedge sys_clk)
  begin
    if (ld_en)
      mem_reg[rd_addr] <= ld_data;
    else if (wr_en && wr_addr[15:8] == 8'h00)
      mem_reg[wr_addr[7:0]] <= wr_data;
  end
endmodule
`default_nettype wire

// ==== rel_branch_unit.sv ====
// Branch condition evaluation and relative target adder
`default_nettype none
module rel_branch_unit
  import cpu_decode_pkg::*;
(
  // Condition select
  input  wire logic [3:0]  cond_sel,
  input  wire logic        bit_test,
  input  wire logic        bit_polarity,
  input  wire logic        bit_value,
  // Condition code and pin state
  input  wire logic        flag_h,
  input  wire logic        flag_i,
  input  wire logic        flag_n,
  input  wire logic        flag_z,
  input  wire logic        flag_c,
  input  wire logic        irq_level,
  // Addresses
  input  wire logic [15:0] seq_pc,
  input  wire logic [7:0]  offset,
  output logic             cond_true,
  output logic [15:0]      target
);
  logic rel_cond;

  always_comb
  begin
    case (cond_sel)
      BR_ALWAYS:   rel_cond = 1'b1;
      BR_NEVER:    rel_cond = 1'b0;                // RULE23
      BR_HI:       rel_cond = ~(flag_c | flag_z);
      BR_LS:       rel_cond = flag_c | flag_z;
      BR_CC:       rel_cond = ~flag_c;
      BR_CS:       rel_cond = flag_c;
      BR_NE:       rel_cond = ~flag_z;
      BR_EQ:       rel_cond = flag_z;
      BR_HCC:      rel_cond = ~flag_h;
      BR_HCS:      rel_cond = flag_h;
      BR_PL:       rel_cond = ~flag_n;
      BR_MI:       rel_cond = flag_n;
      BR_MASK_CLR: rel_cond = ~flag_i;             // RULE21
      BR_MASK_SET: rel_cond = flag_i;              // RULE21
      BR_IRQ_LOW:  rel_cond = ~irq_level;          // RULE21
      BR_IRQ_HIGH: rel_cond = irq_level;           // RULE21
      default:     rel_cond = 1'b0;
    endcase
  end

  assign cond_true = bit_test ? (bit_value == bit_polarity) : rel_cond; // RULE13
  // Sign-extended offset gives -128..+127 from the following instruction
  assign target = seq_pc + {{8{offset[7]}}, offset}; // RULE2 RULE4
endmodule
`default_nettype wire

// ==== testbench.sv ====
// Self-checking bench for the instruction class decoder
`default_nettype none
module testbench;
  import cpu_decode_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [7:0] op, b1, b2; logic [15:0] pc; logic [7:0] mem; logic [4:0] fl;
    logic [2:0] cls; logic [15:0] npc; logic tk, mw, cu, cv; logic [7:0] res;
  } row_type;
  localparam row_type ROWS [21] = '{
    '{8'h27,8'hFE,8'h00,16'h0100,8'h00,5'h02,3'h2,16'h0100,1'b1,1'b0,1'b0,1'bx,8'h00},
    '{8'h27,8'hFE,8'h00,16'h0100,8'h00,5'h00,3'h2,16'h0102,1'b0,1'b0,1'b0,1'bx,8'h00},
    '{8'h20,8'h7F,8'h00,16'h1000,8'h00,5'h00,3'h2,16'h1081,1'b1,1'b0,1'b0,1'bx,8'h00},
    '{8'h20,8'h80,8'h00,16'h1000,8'h00,5'h00,3'h2,16'h0F82,1'b1,1'b0,1'b0,1'bx,8'h00},
    '{8'h21,8'h10,8'h00,16'h0200,8'h00,5'h00,3'h2,16'h0202,1'b0,1'b0,1'b0,1'bx,8'h00},
    '{8'h2C,8'h04,8'h00,16'h0300,8'h00,5'h00,3'h2,16'h0306,1'b1,1'b0,1'b0,1'bx,8'h00},
    '{8'h2D,8'h04,8'h00,16'h0300,8'h00,5'h00,3'h2,16'h0302,1'b0,1'b0,1'b0,1'bx,8'h00},
    '{8'h2F,8'h04,8'h00,16'h0300,8'h00,5'h00,3'h2,16'h0306,1'b1,1'b0,1'b0,1'bx,8'h00},
    '{8'h05,8'h40,8'h10,16'h0400,8'hFB,5'h00,3'h3,16'h0413,1'b1,1'b0,1'b1,1'b0,8'hxx},
    '{8'h04,8'h40,8'h10,16'h0400,8'hFB,5'h00,3'h3,16'h0403,1'b0,1'b0,1'b1,1'b0,8'hxx},
    '{8'h0F,8'h40,8'hF0,16'h0400,8'h80,5'h00,3'h3,16'h0403,1'b0,1'b0,1'b1,1'b1,8'hxx},
    '{8'h1E,8'h55,8'h00,16'h0500,8'h01,5'h00,3'h3,16'h0502,1'b0,1'b1,1'b0,1'bx,8'h81},
    '{8'h11,8'h55,8'h00,16'h0500,8'hFF,5'h00,3'h3,16'h0502,1'b0,1'b1,1'b0,1'bx,8'hFE},
    '{8'h3C,8'h60,8'h00,16'h0500,8'h41,5'h00,3'h1,16'h0502,1'b0,1'b1,1'b0,1'bx,8'h42},
    '{8'h3D,8'h60,8'h00,16'h0500,8'h80,5'h00,3'h1,16'h0502,1'b0,1'b0,1'b0,1'bx,8'h80},
    '{8'h38,8'h60,8'h00,16'h0500,8'h81,5'h00,3'h1,16'h0502,1'b0,1'b1,1'b1,1'b1,8'h02},
    '{8'hCC,8'h12,8'h34,16'h0600,8'h00,5'h00,3'h2,16'h1234,1'b1,1'b0,1'b0,1'bx,8'hxx},
    '{8'h42,8'h00,8'h00,16'h0700,8'h00,5'h00,3'h0,16'h0701,1'b0,1'b0,1'b1,1'b0,8'hA8},
    '{8'hB6,8'h60,8'h00,16'h0700,8'h41,5'h00,3'h0,16'h0702,1'b0,1'b0,1'b0,1'bx,8'hxx},
    '{8'h8E,8'h00,8'h00,16'h0800,8'h00,5'h00,3'h4,16'h0801,1'b0,1'b0,1'b0,1'bx,8'hxx},
    '{8'hAC,8'h00,8'h00,16'h0800,8'h00,5'h00,3'h4,16'h0802,1'b0,1'b0,1'b0,1'bx,8'hxx}};
  logic sys_clk = 1'b0, rst_n = 1'b0, start = 1'b0, irq_pin_n = 1'b1, ld_en = 1'b0;
  logic [7:0] opcode = 8'h00, byte1 = 8'h00, byte2 = 8'h00, ld_data = 8'h00, mem_data;
  logic [7:0] acc = 8'h12, idx = 8'h34, result_data, mul_hi, mul_lo;
  logic [15:0] pc_now = 16'h0000, eff_addr, next_pc;
  logic flag_h = 1'b0, flag_i = 1'b0, flag_n = 1'b0, flag_z = 1'b0, flag_c = 1'b0;
  logic done, mem_write, branch_taken, carry_update, carry_value, result_n, result_z;
  logic stop_req, wait_req, irq_wake_en, mask_clear;
  class_type instr_class;
  int n_fail = 0, samples_checked = 0;
  always #25 sys_clk = ~sys_clk;
  cpu_instruction_class_decode dut_u (.sys_clk, .rst_n, .start, .opcode, .byte1, .byte2,
    .pc_now, .acc, .idx, .flag_h, .flag_i, .flag_n, .flag_z, .flag_c, .mem_data, .irq_pin_n,
    .done, .instr_class, .addr_mode(), .operand_loc(), .eff_addr, .mem_read(), .mem_write,
    .next_pc, .branch_taken, .result_data, .result_n, .result_z, .carry_update,
    .carry_value, .mul_load(), .mul_hi, .mul_lo, .stop_req, .wait_req, .irq_wake_en,
    .mask_clear);
  page_mem_model mem_u (.sys_clk, .rd_addr(byte1), .rd_data(mem_data), .wr_en(mem_write),
    .wr_addr(eff_addr), .wr_data(result_data), .ld_en, .ld_data);
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    if (^e !== 1'bx)
    begin
      samples_checked++;
      if (g !== e)
      begin
        n_fail++;
        $display("mismatch %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  // Preload memory, pulse start once, then wait for done at a falling edge
  task automatic issue(input row_type r);
    int k;
    @(posedge sys_clk);
    {opcode, byte1, byte2, pc_now} <= {r.op, r.b1, r.b2, r.pc};
    {flag_h, flag_i, flag_n, flag_z, flag_c} <= r.fl;
    ld_en <= 1'b1;
    ld_data <= r.mem;
    @(posedge sys_clk);
    ld_en <= 1'b0;
    start <= 1'b1;
    @(posedge sys_clk);
    start <= 1'b0;
    @(negedge sys_clk);
    for (k = 0; k < 4 && done !== 1'b1; k++)
      @(negedge sys_clk);
    chk("done", 16'h0001, {15'h0000, done});
    if (done !== 1'b1)
      summarize();
  endtask
  initial
  begin
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk);
    chk("reset done", 16'h0000, {15'h0000, done});
    chk("reset next_pc", 16'h0000, next_pc);
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    $display("test reset done");
    foreach (ROWS[i])
    begin
      issue(ROWS[i]);
      chk("class", ROWS[i].cls, instr_class);
      chk("next_pc", ROWS[i].npc, next_pc);
      chk("taken", ROWS[i].tk, branch_taken);
      chk("mem_write", ROWS[i].mw, mem_write);
      chk("carry_update", ROWS[i].cu, carry_update);
      chk("carry_value", ROWS[i].cv, carry_value);
      chk("result", ROWS[i].res, result_data);
      chk("nz", {ROWS[i].res[7], ROWS[i].res == 8'h00}, {result_n, result_z});
      if (ROWS[i].op === 8'h42)
        chk("mul", 16'h03A8, {mul_hi, mul_lo});
      if (ROWS[i].op === 8'h8E)
        chk("halt", 16'h0003, {stop_req, irq_wake_en});
      if (ROWS[i].mw === 1'b1)
      begin
        @(negedge sys_clk);
        chk("stored", ROWS[i].res, mem_data);
      end
    end
    $display("test rows done");
    issue('{8'h8F,8'h00,8'h00,16'h0800,8'h00,5'h08,3'h4,16'h0801,1'b0,1'b0,1'b0,1'bx,8'hxx});
    chk("wait", 16'h0003, {wait_req, mask_clear});
    @(negedge sys_clk);
    chk("wait pulse", 16'h0000, {wait_req, mask_clear});
    @(posedge sys_clk);
    irq_pin_n <= 1'b0;
    issue('{8'h2E,8'h04,8'h00,16'h0300,8'h00,5'h00,3'h2,16'h0306,1'b1,1'b0,1'b0,1'bx,8'hxx});
    chk("pin low", 16'h0306, next_pc);
    $display("test pin done");
    @(posedge sys_clk);
    {opcode, byte1, pc_now, start} <= {8'h20, 8'h02, 16'h0900, 1'b1};
    @(posedge sys_clk);
    {opcode, pc_now} <= {8'h21, 16'h0A00};
    @(negedge sys_clk);
    chk("first", 16'h0904, next_pc);
    @(posedge sys_clk);
    start <= 1'b0;
    @(negedge sys_clk);
    chk("second", 16'h0A02, next_pc);
    chk("second done", 16'h0001, {15'h0000, done});
    $display("test back to back done");
    summarize();
  end
endmodule
`default_nettype wire
